// [verilog/flm_pkg.sv]
// Purpose: shared constants, types and helpers of the fast latch and
//          masked write extension register bank
// Assumes: byte-wide indexed host access, four display planes
// Notes:   index values are the extension indices seen by the host
package flm_pkg;

  typedef logic [7:0] flm_byte_t;
  typedef logic [1:0] flm_ptr_t;
  typedef logic [31:0] flm_word_t;

  localparam int FLM_PLANES = 4;
  localparam int FLM_BYTE_W = 8;

  // code that opens the extension registers to the host
  localparam flm_byte_t FLM_UNLOCK_CODE = 8'hea;

  // extension indices
  localparam flm_byte_t IDX_FORE0 = 8'hec;
  localparam flm_byte_t IDX_FORE1 = 8'hed;
  localparam flm_byte_t IDX_FORE2 = 8'hee;
  localparam flm_byte_t IDX_FORE3 = 8'hef;
  localparam flm_byte_t IDX_FAST_FORE = 8'hf0;
  localparam flm_byte_t IDX_LOAD_PTRS = 8'hf1;
  localparam flm_byte_t IDX_FAST_BACK = 8'hf2;
  localparam flm_byte_t IDX_MW_CTRL = 8'hf3;
  localparam flm_byte_t IDX_MW_MASK = 8'hf4;
  localparam flm_byte_t IDX_PATTERN = 8'hf5;

  // load pointer field positions
  localparam int FORE_PTR_LSB = 4;
  localparam int BACK_PTR_LSB = 0;

  // masked write control field positions
  localparam int MW_EN_BIT = 0;
  localparam int MW_SRC_BIT = 1;

  // foreground/background control value that selects the latches
  localparam flm_ptr_t FB_SEL_FORE = 2'h2;

  // reset and idle values
  localparam flm_ptr_t PTR_ZERO = 2'h0;
  localparam flm_ptr_t PTR_ONE = 2'h1;
  localparam flm_ptr_t MW_CTRL_RESET = 2'h0;
  localparam flm_byte_t BYTE_ZERO = 8'h00;
  localparam flm_byte_t MASK_ALL = 8'hff;
  localparam flm_word_t WORD_ZERO = 32'h00000000;

  // modulo-4 advance of a load pointer
  function automatic flm_ptr_t ptr_next(input flm_ptr_t p);
    ptr_next = flm_ptr_t'(p + PTR_ONE);
  endfunction : ptr_next

  // readback image of the load pointer register, unused bits zero
  function automatic flm_byte_t pack_ptrs(input flm_ptr_t f,
                                          input flm_ptr_t b);
    flm_byte_t v;
    v = BYTE_ZERO;
    v[FORE_PTR_LSB +: 2] = f;
    v[BACK_PTR_LSB +: 2] = b;
    pack_ptrs = v;
  endfunction : pack_ptrs

  // readback image of the masked write control, bits 7-2 zero
  function automatic flm_byte_t pack_mw(input flm_ptr_t c);
    flm_byte_t v;
    v = BYTE_ZERO;
    v[MW_EN_BIT] = c[MW_EN_BIT];
    v[MW_SRC_BIT] = c[MW_SRC_BIT];
    pack_mw = v;
  endfunction : pack_mw

endpackage : flm_pkg

// [verilog/flm_unlock.sv]
// Purpose: extension unlock register; opens the extension bank
// Assumes: host writes to the unlock register arrive as a one-cycle strobe
// Notes:   any value other than the code closes the bank again
`timescale 1ns/1ps
module flm_unlock (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_clk_en,
  input wire i_unlock_wr,
  input wire flm_pkg::flm_byte_t i_unlock_data,
  output logic o_unlocked
);
  import flm_pkg::*;

  logic unlocked_r;
  logic unlocked_nxt;

  always_comb begin
    unlocked_nxt = unlocked_r;
    if (i_unlock_wr) begin
      unlocked_nxt = (i_unlock_data == FLM_UNLOCK_CODE);
    end
  end

  // closed after reset so stray accesses cannot reach the bank
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      unlocked_r <= 1'b0;
    end else if (i_clk_en) begin
      unlocked_r <= unlocked_nxt;
    end
  end

  assign o_unlocked = unlocked_r;

endmodule : flm_unlock

// [verilog/flm_mask_unit.sv]
// Purpose: selects the write-per-bit mask for a display memory write
// Assumes: rotated cpu byte is supplied by the data rotator outside
// Notes:   purely combinational; the top registers the result
`timescale 1ns/1ps
module flm_mask_unit (
  input wire flm_pkg::flm_ptr_t i_mw_ctrl,
  input wire flm_pkg::flm_byte_t i_stored_mask,
  input wire flm_pkg::flm_byte_t i_rot_byte,
  output flm_pkg::flm_byte_t o_mask,
  output logic o_masked
);
  import flm_pkg::*;

  always_comb begin
    o_masked = i_mw_ctrl[MW_EN_BIT];
    if (!i_mw_ctrl[MW_EN_BIT]) begin
      o_mask = MASK_ALL;  // ordinary write: every bit replaced
    end else if (i_mw_ctrl[MW_SRC_BIT]) begin
      o_mask = i_rot_byte;
    end else begin
      o_mask = i_stored_mask;
    end
  end

endmodule : flm_mask_unit

// [verilog/flm_top.sv]
// Purpose: fast latch load ports, foreground latches and masked write
//          control of the display controller extension bank
// Assumes: host index and data strobes are one-cycle pulses, read and
//          write never in the same cycle; memory attached is video ram
// Notes:   background latch storage sits outside, fed by o_back_wr
//
// Summary of operation
// - four plane foreground latches feed alu on 10
// - bank usable only after unlock code written
// - fast fore write stores at pointed plane
// - fore pointer 00..11 selects planes 0..3
// - fore pointer advances modulo four per write
// - fast fore read clears fore pointer
// - fast fore read returns pointed latch
// - fast back write goes to pointed latch
// - back pointer advances modulo four per write
// - fast back read clears back pointer
// - fast back port is decode only
// - masked write only while enable bit set
// - mask from rotated byte or stored mask
// - one mask applies to all planes
// - mask zero keeps bit, one replaces
// - unused control bits read as zero
`timescale 1ns/1ps
module flm_top (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_clk_en,
  input wire i_unlock_wr,
  input wire flm_pkg::flm_byte_t i_unlock_data,
  input wire i_idx_wr,
  input wire i_data_wr,
  input wire i_data_rd,
  input wire flm_pkg::flm_byte_t i_wdata,
  input wire flm_pkg::flm_ptr_t i_fb_sel,
  input wire flm_pkg::flm_word_t i_gc_alu_in,
  input wire i_mem_wr,
  input wire flm_pkg::flm_byte_t i_rot_byte,
  input wire flm_pkg::flm_word_t i_mem_wdata,
  output flm_pkg::flm_byte_t o_rd_data,
  output logic o_rd_valid,
  output logic o_unlocked,
  output logic o_back_wr,
  output flm_pkg::flm_ptr_t o_back_plane,
  output flm_pkg::flm_byte_t o_back_data,
  output flm_pkg::flm_word_t o_alu_in,
  output logic o_vram_we,
  output logic o_vram_masked,
  output flm_pkg::flm_byte_t o_vram_mask,
  output flm_pkg::flm_word_t o_vram_data
);
  import flm_pkg::*;

  // register state
  flm_byte_t fore_r [FLM_PLANES];
  flm_byte_t fore_nxt [FLM_PLANES];
  flm_byte_t idx_r, idx_nxt;
  flm_ptr_t ptr_fore_r, ptr_fore_nxt;
  flm_ptr_t ptr_back_r, ptr_back_nxt;
  flm_ptr_t mw_ctrl_r, mw_ctrl_nxt;
  flm_byte_t mask_r, mask_nxt;
  flm_byte_t pat_r, pat_nxt;

  // output state
  flm_byte_t rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic back_wr_r, back_wr_nxt;
  flm_ptr_t back_plane_r, back_plane_nxt;
  flm_byte_t back_data_r, back_data_nxt;
  flm_word_t alu_in_r, alu_in_nxt;
  logic vram_we_r, vram_we_nxt;
  logic vram_masked_r, vram_masked_nxt;
  flm_byte_t vram_mask_r, vram_mask_nxt;
  flm_word_t vram_data_r, vram_data_nxt;

  logic unlocked;
  logic acc_wr;
  logic acc_rd;
  flm_byte_t sel_mask;
  logic sel_masked;
  flm_word_t fore_flat;

  flm_unlock u_unlock (
    .i_core_clk (i_core_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en (i_clk_en),
    .i_unlock_wr (i_unlock_wr),
    .i_unlock_data (i_unlock_data),
    .o_unlocked (unlocked)
  );

  flm_mask_unit u_mask (
    .i_mw_ctrl (mw_ctrl_r),
    .i_stored_mask (mask_r),
    .i_rot_byte (i_rot_byte),
    .o_mask (sel_mask),
    .o_masked (sel_masked)
  );

  // data accesses only pass while the bank is open
  assign acc_wr = i_data_wr && unlocked;
  assign acc_rd = i_data_rd && unlocked && !i_data_wr;

  // plane 0 in the low byte of the alu word
  assign fore_flat = {fore_r[3], fore_r[2], fore_r[1], fore_r[0]};

  // register bank next state: writes, pointer steps and read side effects
  always_comb begin
    fore_nxt = fore_r;
    idx_nxt = idx_r;
    ptr_fore_nxt = ptr_fore_r;
    ptr_back_nxt = ptr_back_r;
    mw_ctrl_nxt = mw_ctrl_r;
    mask_nxt = mask_r;
    pat_nxt = pat_r;
    // index port itself is never locked, so software can always set it
    if (i_idx_wr) begin
      idx_nxt = i_wdata;
    end
    if (acc_wr) begin
      unique case (idx_r)
        IDX_FORE0, IDX_FORE1, IDX_FORE2, IDX_FORE3: begin
          fore_nxt[idx_r[1:0]] = i_wdata;
        end
        IDX_FAST_FORE: begin
          fore_nxt[ptr_fore_r] = i_wdata;
          ptr_fore_nxt = ptr_next(ptr_fore_r);
        end
        IDX_LOAD_PTRS: begin
          ptr_fore_nxt = i_wdata[FORE_PTR_LSB +: 2];
          ptr_back_nxt = i_wdata[BACK_PTR_LSB +: 2];
        end
        IDX_FAST_BACK: begin
          ptr_back_nxt = ptr_next(ptr_back_r);
        end
        IDX_MW_CTRL: begin
          mw_ctrl_nxt = i_wdata[1:0];
        end
        IDX_MW_MASK: begin
          mask_nxt = i_wdata;
        end
        IDX_PATTERN: begin
          pat_nxt = i_wdata;
        end
        default: begin
        end
      endcase
    end else if (acc_rd) begin
      // read of fast fore port clears pointer
      if (idx_r == IDX_FAST_FORE) begin
        ptr_fore_nxt = PTR_ZERO;
      end
      // read of fast back port clears pointer
      if (idx_r == IDX_FAST_BACK) begin
        ptr_back_nxt = PTR_ZERO;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int p = 0; p < FLM_PLANES; p++) begin
        fore_r[p] <= BYTE_ZERO;
      end
      idx_r <= BYTE_ZERO;
      ptr_fore_r <= PTR_ZERO;
      ptr_back_r <= PTR_ZERO;
      mw_ctrl_r <= MW_CTRL_RESET;
      mask_r <= BYTE_ZERO;
      pat_r <= BYTE_ZERO;
    end else if (i_clk_en) begin
      fore_r <= fore_nxt;
      idx_r <= idx_nxt;
      ptr_fore_r <= ptr_fore_nxt;
      ptr_back_r <= ptr_back_nxt;
      mw_ctrl_r <= mw_ctrl_nxt;
      mask_r <= mask_nxt;
      pat_r <= pat_nxt;
    end
  end

  // outputs: readback, background load strobe, alu source, memory write
  always_comb begin
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    back_wr_nxt = 1'b0;
    back_plane_nxt = back_plane_r;
    back_data_nxt = back_data_r;
    vram_we_nxt = i_mem_wr;
    vram_masked_nxt = vram_masked_r;
    vram_mask_nxt = vram_mask_r;
    vram_data_nxt = vram_data_r;
    // foreground latches drive the alu on the 10 selection
    alu_in_nxt = (i_fb_sel == FB_SEL_FORE) ? fore_flat : i_gc_alu_in;
    if (i_data_rd) begin
      // a locked read still answers, with zero, so the bus never hangs
      rd_valid_nxt = 1'b1;
      rd_data_nxt = BYTE_ZERO;
      if (acc_rd) begin
        unique case (idx_r)
          IDX_FORE0, IDX_FORE1, IDX_FORE2, IDX_FORE3: begin
            rd_data_nxt = fore_r[idx_r[1:0]];
          end
          IDX_FAST_FORE: rd_data_nxt = fore_r[ptr_fore_r];
          IDX_LOAD_PTRS: rd_data_nxt = pack_ptrs(ptr_fore_r, ptr_back_r);
          IDX_MW_CTRL: rd_data_nxt = pack_mw(mw_ctrl_r);
          IDX_MW_MASK: rd_data_nxt = mask_r;
          IDX_PATTERN: rd_data_nxt = pat_r;
          default: rd_data_nxt = BYTE_ZERO;
        endcase
      end
    end
    // route write to pointed background latch
    if (acc_wr && (idx_r == IDX_FAST_BACK)) begin
      back_wr_nxt = 1'b1;
      back_plane_nxt = ptr_back_r;
      back_data_nxt = i_wdata;
    end
    // one mask for all planes; the ram keeps bits at zero
    if (i_mem_wr) begin
      vram_masked_nxt = sel_masked;
      vram_mask_nxt = sel_mask;
      vram_data_nxt = i_mem_wdata;
    end
  end

  // every output is a flop; strobes drop to zero under reset
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rd_data_r <= BYTE_ZERO;
      rd_valid_r <= 1'b0;
      back_wr_r <= 1'b0;
      back_plane_r <= PTR_ZERO;
      back_data_r <= BYTE_ZERO;
      alu_in_r <= WORD_ZERO;
      vram_we_r <= 1'b0;
      vram_masked_r <= 1'b0;
      vram_mask_r <= MASK_ALL;
      vram_data_r <= WORD_ZERO;
    end else if (i_clk_en) begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      back_wr_r <= back_wr_nxt;
      back_plane_r <= back_plane_nxt;
      back_data_r <= back_data_nxt;
      alu_in_r <= alu_in_nxt;
      vram_we_r <= vram_we_nxt;
      vram_masked_r <= vram_masked_nxt;
      vram_mask_r <= vram_mask_nxt;
      vram_data_r <= vram_data_nxt;
    end
  end

  assign o_rd_data = rd_data_r;
  assign o_rd_valid = rd_valid_r;
  assign o_unlocked = unlocked;
  assign o_back_wr = back_wr_r;
  assign o_back_plane = back_plane_r;
  assign o_back_data = back_data_r;
  assign o_alu_in = alu_in_r;
  assign o_vram_we = vram_we_r;
  assign o_vram_masked = vram_masked_r;
  assign o_vram_mask = vram_mask_r;
  assign o_vram_data = vram_data_r;

  // checks on the register bank behaviour
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_fore_wr;
    i_clk_en && acc_wr && (idx_r == IDX_FAST_FORE);
  endsequence

  sequence s_fore_rd;
    i_clk_en && acc_rd && (idx_r == IDX_FAST_FORE);
  endsequence

  sequence s_back_wr;
    i_clk_en && acc_wr && (idx_r == IDX_FAST_BACK);
  endsequence

  fore_ptr_step_a: assert property (
    s_fore_wr |=> ptr_fore_r == ptr_next($past(ptr_fore_r)))
    else $error("fore pointer did not advance");

  fore_store_a: assert property (
    s_fore_wr |=> fore_r[$past(ptr_fore_r)] == $past(i_wdata))
    else $error("fast fore write not stored at pointed plane");

  fore_ptr_clear_a: assert property (
    s_fore_rd |=> ptr_fore_r == PTR_ZERO && o_rd_valid
      && o_rd_data == $past(fore_r[ptr_fore_r]))
    else $error("fast fore read did not clear pointer");

  back_ptr_step_a: assert property (
    s_back_wr |=> ptr_back_r == ptr_next($past(ptr_back_r)))
    else $error("back pointer did not advance");

  back_ptr_clear_a: assert property (
    (i_clk_en && acc_rd && idx_r == IDX_FAST_BACK) |=> ptr_back_r == PTR_ZERO)
    else $error("back pointer not cleared by read");

  back_strobe_a: assert property (
    s_back_wr |=> o_back_wr && o_back_plane == $past(ptr_back_r)
      && o_back_data == $past(i_wdata) ##1 (!o_back_wr || !$past(i_clk_en)
      || $past(acc_wr)))
    else $error("background load strobe wrong");

  locked_hold_a: assert property (
    (i_clk_en && !unlocked && i_data_wr) |=> $stable(mw_ctrl_r)
      && $stable(mask_r) && $stable(ptr_fore_r) && !o_back_wr)
    else $error("locked bank was modified");

  ctrl_unused_zero_a: assert property (
    (i_clk_en && acc_rd && idx_r == IDX_MW_CTRL) |=> o_rd_valid
      && o_rd_data[7:2] == 6'h00)
    else $error("unused control bits read nonzero");

  alu_fore_sel_a: assert property (
    (i_clk_en && i_fb_sel == FB_SEL_FORE) |=> o_alu_in == $past(fore_flat))
    else $error("alu not fed from foreground latches");

  mask_source_a: assert property (
    (i_clk_en && i_mem_wr && mw_ctrl_r[MW_EN_BIT]) |=> o_vram_we
      && o_vram_masked && o_vram_mask == ($past(mw_ctrl_r[MW_SRC_BIT])
      ? $past(i_rot_byte) : $past(mask_r)))
    else $error("masked write used wrong mask");

  plain_write_a: assert property (
    (i_clk_en && i_mem_wr && !mw_ctrl_r[MW_EN_BIT]) |=> o_vram_we
      && !o_vram_masked && o_vram_mask == MASK_ALL)
    else $error("ordinary write was masked");

endmodule : flm_top

// [dv/flm_host_model.sv]
// Purpose: host cpu model on the indexed extension port
// Assumes: strobes are launched at the falling edge, one cycle each
// Notes:   idle bus carries the inverse of the last byte, so a design
//          that samples stale data cannot pass by luck
`timescale 1ns/1ps
module flm_host_model (
  input wire i_core_clk,
  input wire flm_pkg::flm_byte_t i_rd_data,
  input wire i_rd_valid,
  output logic o_unlock_wr,
  output flm_pkg::flm_byte_t o_unlock_data,
  output logic o_idx_wr,
  output logic o_data_wr,
  output logic o_data_rd,
  output flm_pkg::flm_byte_t o_wdata
);
  import flm_pkg::*;

  // bus idle at time zero
  initial begin
    {o_unlock_wr, o_idx_wr, o_data_wr, o_data_rd} = 4'h0;
    o_unlock_data = 8'h00;
    o_wdata = 8'h00;
  end

  // one strobe cycle: 0 unlock, 1 index, 2 data write, 3 data read
  task automatic pulse(input int sel, input flm_byte_t d);
    @(negedge i_core_clk);
    o_unlock_wr = (sel == 0);
    o_idx_wr = (sel == 1);
    o_data_wr = (sel == 2);
    o_data_rd = (sel == 3);
    o_unlock_data = d;
    o_wdata = d;
    @(negedge i_core_clk);
    {o_unlock_wr, o_idx_wr, o_data_wr, o_data_rd} = 4'h0;
    o_unlock_data = ~d;
    o_wdata = ~d;
  endtask : pulse

  // host writes the code before touching the bank
  task automatic unl(input flm_byte_t d);
    pulse(0, d);
  endtask : unl

  // attached memory is taken to be video ram
  task automatic wr(input flm_byte_t idx, input flm_byte_t d);
    pulse(1, idx);
    pulse(2, d);
  endtask : wr

  // read answer is sampled in the cycle after the read strobe
  task automatic rd(input flm_byte_t idx, output logic [8:0] r);
    pulse(1, idx);
    pulse(3, 8'h00);
    r = {i_rd_valid, i_rd_data};
  endtask : rd
endmodule : flm_host_model

// [dv/tb_top.sv]
// Purpose: self-checking bench of the fast latch and masked write bank
// Assumes: clock enable held high except for one frozen unlock write in t_lock; video ram attached
// Notes:   expectations are computed here, never read from the design
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_top;
  import flm_pkg::*;
  logic clk, rst, en, unl_wr, idx_wr, d_wr, d_rd, mem_wr;
  flm_byte_t unl_d, wd, rot, rdd, bd, vmk;
  flm_ptr_t fb_sel, bpl;
  flm_word_t gc, mwd, alu, vd;
  logic rdv, unlocked, bwr, vwe, vms;
  int mismatches = 0;
  int n_tests = 0;

  // 25 MHz core clock
  always #20 clk = ~clk;

  flm_top dut (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(en),
    .i_unlock_wr(unl_wr), .i_unlock_data(unl_d), .i_idx_wr(idx_wr),
    .i_data_wr(d_wr), .i_data_rd(d_rd), .i_wdata(wd), .i_fb_sel(fb_sel),
    .i_gc_alu_in(gc), .i_mem_wr(mem_wr), .i_rot_byte(rot),
    .i_mem_wdata(mwd), .o_rd_data(rdd), .o_rd_valid(rdv),
    .o_unlocked(unlocked), .o_back_wr(bwr), .o_back_plane(bpl),
    .o_back_data(bd), .o_alu_in(alu), .o_vram_we(vwe),
    .o_vram_masked(vms), .o_vram_mask(vmk), .o_vram_data(vd));

  flm_host_model host (.i_core_clk(clk), .i_rd_data(rdd),
    .i_rd_valid(rdv), .o_unlock_wr(unl_wr), .o_unlock_data(unl_d),
    .o_idx_wr(idx_wr), .o_data_wr(d_wr), .o_data_rd(d_rd), .o_wdata(wd));

  // verdict and end of run
  task automatic test_done();
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // closed bank ignores writes; reset values once opened
  task automatic t_lock();
    logic [8:0] r;
    `CHK(vmk, MASK_ALL)
    host.unl(8'h00);
    `CHK(unlocked, 1'b0)
    host.wr(IDX_FORE0, 8'h5a);
    host.rd(IDX_FORE0, r);
    `CHK(r, 9'h100)
    host.unl(FLM_UNLOCK_CODE);
    `CHK(unlocked, 1'b1)
    host.rd(IDX_FORE0, r);
    `CHK(r, 9'h100)
    host.rd(IDX_LOAD_PTRS, r);
    `CHK(r, 9'h100)
    host.rd(IDX_MW_CTRL, r);
    `CHK(r, 9'h100)
    host.wr(IDX_PATTERN, 8'h96);
    host.rd(IDX_PATTERN, r);
    `CHK(r, 9'h196)
    // a frozen clock enable must swallow a closing unlock write
    en = 1'b0;
    host.unl(8'h00);
    en = 1'b1;
    `CHK(unlocked, 1'b1)
  endtask : t_lock

  // fast foreground loading with wrap, then latches on the alu path
  task automatic t_fore();
    logic [8:0] r;
    flm_byte_t e[4] = '{8'h55, 8'h22, 8'h33, 8'h44};
    host.wr(IDX_LOAD_PTRS, 8'h20);
    host.rd(IDX_FAST_FORE, r);
    host.rd(IDX_LOAD_PTRS, r);
    `CHK(r, 9'h100)
    // fifth write wraps back onto plane 0
    for (int i = 0; i < 5; i++) begin
      host.wr(IDX_FAST_FORE, flm_byte_t'(8'h11 * (i + 1)));
    end
    host.rd(IDX_LOAD_PTRS, r);
    `CHK(r, 9'h110)
    for (int i = 0; i < 4; i++) begin
      host.rd(flm_byte_t'(IDX_FORE0 + i), r);
      `CHK(r, {1'b1, e[i]})
    end
    host.rd(IDX_FAST_FORE, r);
    `CHK(r, 9'h122)
    fb_sel = FB_SEL_FORE;
    repeat (2) @(negedge clk);
    `CHK(alu, 32'h44332255)
    fb_sel = 2'h0;
    gc = 32'h0badf00d;
    repeat (2) @(negedge clk);
    `CHK(alu, 32'h0badf00d)
  endtask : t_fore

  // fast background loading from pointer 3 with wrap, then clear
  task automatic t_back();
    logic [8:0] r;
    flm_byte_t b;
    host.wr(IDX_LOAD_PTRS, 8'h03);
    for (int i = 0; i < 4; i++) begin
      b = flm_byte_t'(8'ha0 + i);
      host.wr(IDX_FAST_BACK, b);
      `CHK({bwr, bpl, bd}, {1'b1, flm_ptr_t'(3 + i), b})
    end
    host.rd(IDX_LOAD_PTRS, r);
    `CHK(r, 9'h103)
    `CHK(bwr, 1'b0)
    host.rd(IDX_FAST_BACK, r);
    `CHK(r, 9'h100)
    host.rd(IDX_LOAD_PTRS, r);
    `CHK(r, 9'h100)
  endtask : t_back

  // every enable and source setting of the masked write control
  task automatic t_mask();
    logic [8:0] r;
    logic [1:0] c;
    flm_byte_t e;
    host.wr(IDX_MW_MASK, 8'h3c);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      host.wr(IDX_MW_CTRL, {6'h3f, c});
      host.rd(IDX_MW_CTRL, r);
      `CHK(r, {1'b1, 6'h00, c})
      @(negedge clk);
      mem_wr = 1'b1;
      rot = 8'ha5;
      mwd = 32'h12345678 + i;
      @(negedge clk);
      mem_wr = 1'b0;
      rot = 8'h5a;
      e = c[0] ? (c[1] ? 8'ha5 : 8'h3c) : MASK_ALL;
      `CHK({vwe, vms, vmk}, {1'b1, c[0], e})
      `CHK(vd, 32'h12345678 + i)
    end
  endtask : t_mask

  // reset, then the scenarios in turn
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    en = 1'b1;
    fb_sel = 2'h0;
    gc = 32'h0;
    mem_wr = 1'b0;
    rot = 8'h00;
    mwd = 32'h0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_lock();
    t_fore();
    t_back();
    t_mask();
    test_done();
  end

  // scenarios need under two hundred cycles; this cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule : tb_top
